// file: rtl/sbr_pkg.sv
// Package: offsets, field positions, write masks and address bases of the sleep hold bank
package sbr_pkg;
	localparam logic [7:0] ADDR_BUS_CFG = 8'h26;
	localparam logic [7:0] ADDR_HOLD_LOW = 8'h27;
	localparam logic [7:0] ADDR_HOLD_HIGH = 8'h28;
	localparam int SCALE_SEL_LSB = 6;
	localparam int GEN_SEL_LSB = 4;
	localparam int BUCK_HOLD_LSB = 2;
	localparam logic [7:0] BUS_CFG_WMASK = 8'h0f;
	localparam logic [7:0] HOLD_HIGH_WMASK = 8'h3f;
	localparam logic [6:0] SCALE_ADDR_BASE = 7'h12;
	localparam logic [6:0] GEN_ADDR_BASE = 7'h2d;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {SBR_ACTIVE, SBR_SLEEP} sbr_pwr_t;
	typedef enum logic [1:0] {SBR_RUN, SBR_ECO, SBR_OFF} sbr_mode_t;
endpackage : sbr_pkg

// file: rtl/sbr_sync.sv
// Three-stage synchroniser with agreement filter for the sleep pin
`timescale 1ns/1ps
module sbr_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	import sbr_pkg::*;
	logic [SYNC_STAGES-1:0] sh_q;
	logic [SYNC_STAGES-1:0] sh_d;
	logic out_q;
	logic out_d;
	always_comb begin
		sh_d = {sh_q[SYNC_STAGES-2:0], din};
		out_d = out_q;
		// Stage 0 feeds only stage 1; stages 1 and 2 must agree
		if (sh_q[1] == sh_q[2]) begin
			out_d = sh_q[2];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q <= '0;
			out_q <= 1'b0;
		end else if (ce) begin
			sh_q <= sh_d;
			out_q <= out_d;
		end
	end
	assign dout = out_q;
endmodule : sbr_sync

// file: rtl/sbr_regs.sv
// Sleep hold and bus assignment register bank with sleep-state regulator modes
`timescale 1ns/1ps
module sbr_regs (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic [7:0] OTP_BUS_CFG,
	input wire logic [7:0] OTP_HOLD_LOW,
	input wire logic [7:0] OTP_HOLD_HIGH,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic SLEEP_PIN,
	input wire logic SLEEP_ENABLE,
	input wire logic SLEEP_PIN_POLARITY,
	input wire logic IRQ_PENDING,
	input wire logic [9:0] SLEEP_SHUTOFF_SELECT,
	input wire logic [3:0] BUCK_FORCED_MODE,
	output logic [6:0] SCALING_PORT_ADDR,
	output logic [6:0] GENERAL_PORT_ADDR,
	output logic [3:0] BUCK_PORT_ASSIGN,
	output logic IN_SLEEP,
	output logic [13:0] REG_ECO,
	output logic [13:0] REG_OFF
);
	import sbr_pkg::*;
	// ****************************************
	// Register bank
	// ****************************************
	logic loaded_q;
	logic loaded_d;
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic [7:0] hlo_q;
	logic [7:0] hlo_d;
	logic [7:0] hhi_q;
	logic [7:0] hhi_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
			input logic [7:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge
	always_comb begin
		loaded_d = 1'b1;
		cfg_d = cfg_q;
		hlo_d = hlo_q;
		hhi_d = hhi_q;
		rdata_d = rdata_q;
		rvalid_d = REG_RD;
		if (!loaded_q) begin
			// Defaults are captured after reset release, not under the async reset
			cfg_d = OTP_BUS_CFG;
			hlo_d = OTP_HOLD_LOW;
			hhi_d = OTP_HOLD_HIGH & HOLD_HIGH_WMASK;
		end else if (REG_WR) begin
			case (REG_ADDR)
				ADDR_BUS_CFG: cfg_d = merge(cfg_q, REG_WDATA, BUS_CFG_WMASK);
				ADDR_HOLD_LOW: hlo_d = REG_WDATA;
				ADDR_HOLD_HIGH: hhi_d = merge(hhi_q, REG_WDATA, HOLD_HIGH_WMASK);
				default: ;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				ADDR_BUS_CFG: rdata_d = cfg_q;
				ADDR_HOLD_LOW: rdata_d = hlo_q;
				ADDR_HOLD_HIGH: rdata_d = hhi_q & HOLD_HIGH_WMASK;
				default: rdata_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			loaded_q <= 1'b0;
			cfg_q <= 8'h00;
			hlo_q <= 8'h00;
			hhi_q <= 8'h00;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else if (CE) begin
			loaded_q <= loaded_d;
			cfg_q <= cfg_d;
			hlo_q <= hlo_d;
			hhi_q <= hhi_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end
	// ****************************************
	// Sleep state and regulator modes
	// ****************************************
	logic pin_sync;
	logic want_sleep;
	sbr_pwr_t pwr_q;
	sbr_pwr_t pwr_d;
	logic sleep_q;
	logic sleep_d;
	logic [6:0] sa_q;
	logic [6:0] sa_d;
	logic [6:0] ga_q;
	logic [6:0] ga_d;
	logic [3:0] pa_q;
	logic [3:0] pa_d;
	logic [13:0] eco_q;
	logic [13:0] eco_d;
	logic [13:0] off_q;
	logic [13:0] off_d;
	logic [13:0] hold;
	logic [13:0] shut;
	logic [13:0] eco_ok;
	sbr_mode_t m;
	// Target address is a base plus the two-bit select
	function automatic logic [6:0] port_addr(input logic [6:0] base, input logic [1:0] sel);
		port_addr = base + {5'h00, sel};
	endfunction : port_addr
	// Mode of one regulator; only a sleeping, unheld one may drop
	function automatic sbr_mode_t reg_mode(input logic slp, input logic hld, input logic sht,
			input logic eco);
		reg_mode = SBR_RUN;
		if (slp && !hld) begin
			if (sht) begin
				reg_mode = SBR_OFF;
			end else if (eco) begin
				reg_mode = SBR_ECO;
			end
		end
	endfunction : reg_mode
	sbr_sync u_sync (
		.clk(CLK_SYS),
		.rst_n(RESET_N),
		.ce(CE),
		.din(SLEEP_PIN),
		.dout(pin_sync)
	);
	// Polarity is applied after the synchroniser, so a polarity change acts at once
	always_comb begin
		want_sleep = SLEEP_ENABLE && !IRQ_PENDING
			&& (pin_sync ^ SLEEP_PIN_POLARITY);
		case (pwr_q)
			SBR_ACTIVE: pwr_d = want_sleep ? SBR_SLEEP : SBR_ACTIVE;
			// Any wake condition ends sleep on the next edge
			SBR_SLEEP: pwr_d = want_sleep ? SBR_SLEEP : SBR_ACTIVE;
			default: pwr_d = SBR_ACTIVE;
		endcase
		sleep_d = (pwr_d == SBR_SLEEP);
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			pwr_q <= SBR_ACTIVE;
			sleep_q <= 1'b0;
		end else if (CE) begin
			pwr_q <= pwr_d;
			sleep_q <= sleep_d;
		end
	end
	// ****************************************
	// Port addresses and converter ownership
	// ****************************************
	always_comb begin
		sa_d = port_addr(SCALE_ADDR_BASE, cfg_q[SCALE_SEL_LSB +: 2]);
		ga_d = port_addr(GEN_ADDR_BASE, cfg_q[GEN_SEL_LSB +: 2]);
		pa_d = cfg_q[3:0];
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			sa_q <= 7'h00;
			ga_q <= 7'h00;
			pa_q <= 4'h0;
		end else if (CE) begin
			sa_q <= sa_d;
			ga_q <= ga_d;
			pa_q <= pa_d;
		end
	end
	// ****************************************
	// Regulator modes in sleep
	// ****************************************
	always_comb begin
		// Hold vector: LDO1..8, LDO9, LDO10, then bucks 1..4
		hold = {hhi_q[BUCK_HOLD_LSB +: 4], hhi_q[1:0], hlo_q};
		// Bucks have no shut-off select here, so they can only drop to eco
		shut = {4'h0, SLEEP_SHUTOFF_SELECT};
		eco_ok = {~BUCK_FORCED_MODE, 10'h3ff};
		eco_d = 14'h0000;
		off_d = 14'h0000;
		m = SBR_RUN;
		for (int i = 0; i < 14; i++) begin
			m = reg_mode(sleep_q, hold[i], shut[i], eco_ok[i]);
			case (m)
				SBR_ECO: eco_d[i] = 1'b1;
				SBR_OFF: off_d[i] = 1'b1;
				default: ;
			endcase
		end
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			eco_q <= 14'h0000;
			off_q <= 14'h0000;
		end else if (CE) begin
			eco_q <= eco_d;
			off_q <= off_d;
		end
	end
	assign REG_RDATA = rdata_q;
	assign REG_RVALID = rvalid_q;
	assign SCALING_PORT_ADDR = sa_q;
	assign GENERAL_PORT_ADDR = ga_q;
	assign BUCK_PORT_ASSIGN = pa_q;
	assign IN_SLEEP = sleep_q;
	assign REG_ECO = eco_q;
	assign REG_OFF = off_q;
endmodule : sbr_regs

// file: bench/sbr_host.sv
// Host model: register strobes of the sleep hold bank
`timescale 1ns/1ps
module sbr_host (
	input wire logic clk,
	output logic wr,
	output logic rd,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	// One strobe per byte; address and data stand until the taking edge
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr8
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		// Data and valid stand for the cycle after the taking edge
		@(posedge clk);
		d = rvalid ? rdata : 8'hxx;
	endtask : rd8
endmodule : sbr_host

// file: bench/sbr_regs_sva.sv
// Checker: port relations of the sleep hold bank
`timescale 1ns/1ps
module sbr_regs_sva (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] OTP_BUS_CFG,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic SLEEP_ENABLE,
	input wire logic IRQ_PENDING,
	input wire logic [9:0] SLEEP_SHUTOFF_SELECT,
	input wire logic [3:0] BUCK_FORCED_MODE,
	input wire logic [6:0] SCALING_PORT_ADDR,
	input wire logic [6:0] GENERAL_PORT_ADDR,
	input wire logic IN_SLEEP,
	input wire logic [13:0] REG_ECO,
	input wire logic [13:0] REG_OFF
);
	logic [1:0] up_q;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// Defaults land a few edges after release, so address checks wait
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) up_q <= 2'h0;
		else if (CE && up_q != 2'h3) up_q <= up_q + 2'h1;
	end
	property p_sa; up_q == 2'h3 |-> SCALING_PORT_ADDR == 7'h12 + OTP_BUS_CFG[7:6]; endproperty
	a_sa: assert property (p_sa) else $error("scaling address wrong");
	property p_ga; up_q == 2'h3 |-> GENERAL_PORT_ADDR == 7'h2d + OTP_BUS_CFG[5:4]; endproperty
	a_ga: assert property (p_ga) else $error("general address wrong");
	property p_rv; REG_RD && CE |=> REG_RVALID; endproperty
	a_rv: assert property (p_rv) else $error("no read valid");
	property p_um; REG_RD && CE && REG_ADDR > 8'h28 |=> REG_RDATA == 8'h00; endproperty
	a_um: assert property (p_um) else $error("unmapped read not zero");
	property p_rs; REG_RD && CE && REG_ADDR == 8'h28 |=> REG_RDATA[7:6] == 2'h0; endproperty
	a_rs: assert property (p_rs) else $error("reserved bits set");
	property p_aw; !IN_SLEEP [*2] |=> REG_ECO == 14'h0 && REG_OFF == 14'h0; endproperty
	a_aw: assert property (p_aw) else $error("low mode while awake");
	property p_ex; (REG_ECO & REG_OFF) == 14'h0; endproperty
	a_ex: assert property (p_ex) else $error("eco and off together");
	property p_fm; CE |=> (REG_ECO[13:10] & $past(BUCK_FORCED_MODE)) == 4'h0; endproperty
	a_fm: assert property (p_fm) else $error("forced buck in eco");
	property p_sh;
		CE |=> (REG_OFF[9:0] & ~$past(SLEEP_SHUTOFF_SELECT)) == 10'h000
			&& REG_OFF[13:10] == 4'h0;
	endproperty
	a_sh: assert property (p_sh) else $error("off without shut-off select");
	property p_sl; $rose(IN_SLEEP) |-> $past(SLEEP_ENABLE && !IRQ_PENDING); endproperty
	a_sl: assert property (p_sl) else $error("sleep entered illegally");
	c_sl: cover property ($rose(IN_SLEEP));
	c_um: cover property (REG_RVALID && REG_RDATA == 8'h00);
	c_of: cover property (REG_OFF != 14'h0);
endmodule : sbr_regs_sva
bind sbr_regs sbr_regs_sva u_sva (.*);

// file: bench/sbr_regs_tb.sv
// Testbench: register access and sleep modes of the sleep hold bank
`timescale 1ns/1ps
module sbr_regs_tb;
	import sbr_pkg::*;
	logic CLK_SYS, RESET_N, CE, REG_WR, REG_RD, REG_RVALID, SLEEP_PIN, IN_SLEEP;
	logic SLEEP_ENABLE, SLEEP_PIN_POLARITY, IRQ_PENDING;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
	logic [9:0] SLEEP_SHUTOFF_SELECT;
	logic [3:0] BUCK_FORCED_MODE, BUCK_PORT_ASSIGN;
	logic [6:0] SCALING_PORT_ADDR, GENERAL_PORT_ADDR;
	logic [13:0] REG_ECO, REG_OFF;
	logic [7:0] OTP_BUS_CFG = 8'h9a;
	logic [7:0] OTP_HOLD_LOW = 8'h3c;
	logic [7:0] OTP_HOLD_HIGH = 8'hd6;
	int n_mismatch = 0;
	int n_checks = 0;
	sbr_regs uut (.*);
	sbr_host u_host (.clk(CLK_SYS), .wr(REG_WR), .rd(REG_RD), .addr(REG_ADDR),
		.wdata(REG_WDATA), .rdata(REG_RDATA), .rvalid(REG_RVALID));
	task automatic chk(input logic [13:0] s, input logic [13:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic settle;
		repeat (8) @(posedge CLK_SYS);
	endtask : settle
	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		#100000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		{RESET_N, SLEEP_PIN, SLEEP_ENABLE, SLEEP_PIN_POLARITY, IRQ_PENDING} = 5'h00;
		CE = 1'b1;
		SLEEP_SHUTOFF_SELECT = 10'h0f0;
		BUCK_FORCED_MODE = 4'h4;
		repeat (20) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		u_host.rd8(ADDR_BUS_CFG, d);
		chk(d, 8'h9a);
		u_host.rd8(ADDR_HOLD_LOW, d);
		chk(d, 8'h3c);
		u_host.rd8(ADDR_HOLD_HIGH, d);
		chk(d, 8'h16);
		chk(SCALING_PORT_ADDR, 7'h14);
		chk(GENERAL_PORT_ADDR, 7'h2e);
		chk(BUCK_PORT_ASSIGN, 4'ha);
		u_host.wr8(ADDR_BUS_CFG, 8'h05);
		u_host.rd8(ADDR_BUS_CFG, d);
		chk(d, 8'h95);
		chk(BUCK_PORT_ASSIGN, 4'h5);
		u_host.wr8(ADDR_HOLD_HIGH, 8'hc5);
		u_host.rd8(ADDR_HOLD_HIGH, d);
		chk(d, 8'h05);
		u_host.rd8(8'h30, d);
		chk(d, 8'h00);
		u_host.wr8(ADDR_HOLD_LOW, 8'h0f);
		CE <= 1'b0;
		u_host.wr8(ADDR_HOLD_LOW, 8'hf0);
		CE <= 1'b1;
		u_host.rd8(ADDR_HOLD_LOW, d);
		chk(d, 8'h0f);
		SLEEP_ENABLE <= 1'b1;
		SLEEP_PIN <= 1'b1;
		settle;
		chk(IN_SLEEP, 1'b1);
		chk(REG_ECO, 14'h2a00);
		chk(REG_OFF, 14'h00f0);
		SLEEP_PIN_POLARITY <= 1'b1;
		settle;
		chk(REG_ECO, 14'h0);
		IRQ_PENDING <= 1'b1;
		SLEEP_PIN <= 1'b0;
		settle;
		chk(IN_SLEEP, 1'b0);
		IRQ_PENDING <= 1'b0;
		settle;
		chk(IN_SLEEP, 1'b1);
		SLEEP_ENABLE <= 1'b0;
		RESET_N <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		u_host.rd8(ADDR_BUS_CFG, d);
		chk(d, 8'h9a);
		u_host.rd8(ADDR_HOLD_LOW, d);
		chk(d, 8'h3c);
		u_host.rd8(ADDR_HOLD_HIGH, d);
		chk(d, 8'h16);
		chk(BUCK_PORT_ASSIGN, 4'ha);
		chk(IN_SLEEP, 1'b0);
		give_verdict;
	end
endmodule : sbr_regs_tb
